// File: logic/bvs_defs.svh
// constants of the bus verify status sequencer
`ifndef BVS_DEFS_SVH
`define BVS_DEFS_SVH
`define BVS_A_INT 8'h00
`define BVS_A_STAT 8'h04
`define BVS_A_MEM 8'h08
`define BVS_A_DL 8'h0c
`define BVS_SIZE_WORD 3'h2
`define BVS_CODE_P1 16'h0000
`define BVS_CODE_P2 16'h0001
`define BVS_CODE_P3 16'h0002
`define BVS_CODE_P4 16'h0003
`define BVS_CODE_P5 16'h0004
`define BVS_CODE_F55 16'h0055
`define BVS_CODE_F2A 16'h002a
`define BVS_CODE_CMD 16'h0005
`define BVS_PIN_P1 3'h6
`define BVS_PIN_P2 3'h7
`define BVS_PIN_P3 3'h4
`define BVS_PIN_P4 3'h5
`define BVS_PIN_P5 3'h2
`define BVS_CMD_EXEC 8'hc5
`define BVS_CMD_DLOAD 8'h80
`define BVS_TOGGLE_S 4
`define BVS_CLK_HZ 40000000
`define BVS_RING_IDLE 16'h0040
`define BVS_MEM_LO 16'h1006
`define BVS_MEM_HI 16'hbffe
`define BVS_MEM_STEP 16'h0002
`define BVS_MEM_PAT 16'haaaa
`define BVS_DBG_LO 16'h4000
`define BVS_DBG_HI 16'h7ffe
`define BVS_BOOT_WAIT 3'h5
`endif

// File: logic/bvs_pkg.sv
// types of the bus verify status sequencer
`default_nettype none
package bvs_pkg;
  typedef enum logic [6:0] {
    BVS_IDLE = 7'h01,
    BVS_P1 = 7'h02,
    BVS_P2 = 7'h04,
    BVS_P3 = 7'h08,
    BVS_P4 = 7'h10,
    BVS_P5 = 7'h20,
    BVS_CMD = 7'h40
  } bvs_state_t;
  typedef enum logic [3:0] {
    BVS_M_IDLE = 4'h1,
    BVS_M_WR = 4'h2,
    BVS_M_RD = 4'h4,
    BVS_M_CMP = 4'h8
  } bvs_mstate_t;
endpackage : bvs_pkg
`default_nettype wire

// File: logic/bvs_top.sv
// bus verify status sequencer with ahb-lite register slave
//
// Behaviour
// [RL1] phase one: pins 1,1,0, code 0000
// [RL2] phase one pass: pins 1,1,1, code 0001
// [RL3] phase two pass: pins 1,0,0, code 0002
// [RL4] phase three pass: pins 1,0,1, code 0003
// [RL5] phase five: pins 0,1,0, codes 0004/0055/002a
// [RL6] all pass: code 0005, command state
// [RL7] command state toggles insert and loopback pins
// [RL8] failure hangs with pins and code held
// [RL9] pins and code update together; the code updates alone while the ring clock is idle, the pins wait
// [RL10] start on reset release or execute
// [RL11] reset restarts resident, loses downloaded code
// [RL12] handler test low floats status pins
// [RL13] ring registers written only while ring clock toggles
// [RL14] host writes commands into interrupt register
// [RL15] open tests expansion memory 1006 to bffe
// [RL16] data partition only; failure flags expansion error
// [RL17] debug code lives at 4000 to 7ffe
// [RL18] host execute code c5 in download state
// [RL19] toggle interval from parameterised free counter
`default_nettype none
`include "bvs_defs.svh"
module bvs_top
  import bvs_pkg::*;
#(
  parameter int unsigned TOGGLE_CYCLES = `BVS_TOGGLE_S * `BVS_CLK_HZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic phase_pass,
  input wire logic phase_fail,
  input wire logic pattern_fail_55,
  input wire logic pattern_fail_2a,
  input wire logic resident_strap,
  input wire logic ring_clock_in,
  input wire logic handler_test_n,
  output logic frame_acquire_out,
  output logic frame_acquire_oe,
  output logic insert_request_out,
  output logic insert_request_oe,
  output logic loopback_out,
  output logic loopback_oe,
  output logic [7:0] command_out,
  output logic command_strobe,
  output logic [15:0] dl_addr_out,
  output logic [15:0] dl_data_out,
  output logic dl_we_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  output logic mem_we_out,
  output logic mem_re_out,
  input wire logic [15:0] mem_rdata,
  output logic instruction_data_select
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] code_of(input bvs_state_t s);
    unique case (s)
      BVS_IDLE: code_of = `BVS_CODE_P1;
      BVS_P1: code_of = `BVS_CODE_P1; // [RL1]
      BVS_P2: code_of = `BVS_CODE_P2; // [RL2]
      BVS_P3: code_of = `BVS_CODE_P3; // [RL3]
      BVS_P4: code_of = `BVS_CODE_P4; // [RL4]
      BVS_P5: code_of = `BVS_CODE_P5; // [RL5]
      BVS_CMD: code_of = `BVS_CODE_CMD; // [RL6]
      default: code_of = `BVS_CODE_P1;
    endcase
  endfunction : code_of

  function automatic logic [2:0] pins_of(input bvs_state_t s);
    unique case (s)
      BVS_P2: pins_of = `BVS_PIN_P2; // [RL2]
      BVS_P3: pins_of = `BVS_PIN_P3; // [RL3]
      BVS_P4: pins_of = `BVS_PIN_P4; // [RL4]
      BVS_P5: pins_of = `BVS_PIN_P5; // [RL5]
      BVS_CMD: pins_of = `BVS_PIN_P5; // [RL7]
      default: pins_of = `BVS_PIN_P1; // [RL1]
    endcase
  endfunction : pins_of

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] ring_sync;
  logic [2:0] test_sync;
  logic [2:0] strap_sync;
  logic test_filt;
  logic strap_filt;
  logic next_test_filt;
  logic next_strap_filt;
  logic ring_toggle;

  always_comb begin
    next_test_filt = test_filt;
    next_strap_filt = strap_filt;
    if (test_sync[1] == test_sync[2]) begin
      next_test_filt = test_sync[2];
    end
    if (strap_sync[1] == strap_sync[2]) begin
      next_strap_filt = strap_sync[2];
    end
    ring_toggle = ring_sync[1] != ring_sync[2];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_sync <= 3'h0;
      test_sync <= 3'h7;
      strap_sync <= 3'h0;
      test_filt <= 1'b1;
      strap_filt <= 1'b0;
    end else begin
      ring_sync <= {ring_sync[1:0], ring_clock_in};
      test_sync <= {test_sync[1:0], handler_test_n};
      strap_sync <= {strap_sync[1:0], resident_strap};
      test_filt <= next_test_filt;
      strap_filt <= next_strap_filt;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] next_hrdata;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic take;
  logic wr_int;
  logic wr_mem;
  logic wr_dl;
  bvs_state_t state;
  logic failed;
  logic [15:0] int_code;
  logic dl_state;
  logic code_loaded;
  logic ring_active;
  logic mem_err;
  logic mem_ok;
  bvs_mstate_t mstate;

  always_comb begin
    take = hsel && hready && htrans[1] && (hsize == `BVS_SIZE_WORD);
    next_wr_pend = take && hwrite;
    next_wr_addr = take ? haddr[7:0] : wr_addr;
    next_hrdata = 32'h0;
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        `BVS_A_INT: next_hrdata = {16'h0, int_code}; // [RL14]
        `BVS_A_STAT: next_hrdata = {16'h0, loopback_out, insert_request_out,
                                    frame_acquire_out, ring_active, code_loaded,
                                    dl_state, failed, 2'h0, state};
        `BVS_A_MEM: next_hrdata = {29'h0, mem_ok, mem_err, mstate != BVS_M_IDLE};
        `BVS_A_DL: next_hrdata = {dl_addr_out, dl_data_out};
        default: next_hrdata = 32'h0;
      endcase
    end
    wr_int = wr_pend && (wr_addr == `BVS_A_INT);
    wr_mem = wr_pend && (wr_addr == `BVS_A_MEM);
    wr_dl = wr_pend && (wr_addr == `BVS_A_DL);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
    end
  end

  // ---------------------------------------------------------------
  // boot, download and command handling
  // ---------------------------------------------------------------
  logic [2:0] boot_cnt;
  logic [2:0] next_boot_cnt;
  logic boot_go;
  logic exec_go;
  logic next_dl_state;
  logic next_code_loaded;
  logic [7:0] next_command_out;
  logic next_command_strobe;
  logic [15:0] next_dl_addr;
  logic [15:0] next_dl_data;
  logic next_dl_we;

  always_comb begin
    next_boot_cnt = boot_cnt;
    boot_go = 1'b0;
    if (boot_cnt != `BVS_BOOT_WAIT) begin
      next_boot_cnt = boot_cnt + 3'h1;
    end
    if (boot_cnt == (`BVS_BOOT_WAIT - 3'h1)) begin
      boot_go = strap_filt; // [RL10] [RL11]
    end
    next_dl_state = dl_state;
    next_code_loaded = code_loaded;
    next_command_out = command_out;
    next_command_strobe = 1'b0;
    next_dl_addr = dl_addr_out;
    next_dl_data = dl_data_out;
    next_dl_we = 1'b0;
    exec_go = 1'b0;
    if (wr_int) begin
      if (state == BVS_CMD) begin
        next_command_out = hwdata[15:8]; // [RL14]
        next_command_strobe = 1'b1;
      end else if (hwdata[15:8] == `BVS_CMD_DLOAD) begin
        next_dl_state = 1'b1;
      end else if (dl_state && hwdata[15:8] == `BVS_CMD_EXEC && code_loaded) begin
        exec_go = 1'b1; // [RL18] [RL10]
        next_dl_state = 1'b0;
      end
    end
    if (wr_dl && dl_state && in_range(hwdata[31:16], `BVS_DBG_LO, `BVS_DBG_HI)) begin
      next_dl_addr = hwdata[31:16]; // [RL17]
      next_dl_data = hwdata[15:0];
      next_dl_we = 1'b1;
      next_code_loaded = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt <= 3'h0;
      dl_state <= 1'b0;
      code_loaded <= 1'b0; // [RL11]
      command_out <= 8'h0;
      command_strobe <= 1'b0;
      dl_addr_out <= 16'h0;
      dl_data_out <= 16'h0;
      dl_we_out <= 1'b0;
    end else begin
      boot_cnt <= next_boot_cnt;
      dl_state <= next_dl_state;
      code_loaded <= next_code_loaded;
      command_out <= next_command_out;
      command_strobe <= next_command_strobe;
      dl_addr_out <= next_dl_addr;
      dl_data_out <= next_dl_data;
      dl_we_out <= next_dl_we;
    end
  end

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  bvs_state_t next_state;
  logic next_failed;
  logic [15:0] next_int_code;

  always_comb begin
    next_state = state;
    next_failed = failed;
    next_int_code = int_code;
    unique case (state)
      BVS_IDLE: begin
        if (boot_go || exec_go) begin
          next_state = BVS_P1;
        end
      end
      BVS_P1, BVS_P2, BVS_P3, BVS_P4: begin
        if (!failed && phase_fail) begin
          next_failed = 1'b1; // [RL8]
        end else if (!failed && phase_pass) begin
          next_state = bvs_state_t'({state[5:0], 1'b0});
        end
      end
      BVS_P5: begin
        if (!failed && pattern_fail_55) begin
          next_failed = 1'b1;
          next_int_code = `BVS_CODE_F55; // [RL5]
        end else if (!failed && pattern_fail_2a) begin
          next_failed = 1'b1;
          next_int_code = `BVS_CODE_F2A; // [RL5]
        end else if (!failed && phase_fail) begin
          next_failed = 1'b1; // [RL8]
        end else if (!failed && phase_pass) begin
          next_state = BVS_CMD; // [RL6]
        end
      end
      BVS_CMD: next_state = BVS_CMD;
      default: next_state = BVS_IDLE;
    endcase
    if (next_state != state) begin
      next_int_code = code_of(next_state); // [RL9]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= BVS_IDLE;
      failed <= 1'b0;
      int_code <= `BVS_CODE_P1;
    end else begin
      state <= next_state;
      failed <= next_failed;
      int_code <= next_int_code;
    end
  end

  // ---------------------------------------------------------------
  // toggle timer and ring activity
  // ---------------------------------------------------------------
  logic [27:0] tog_cnt;
  logic [27:0] next_tog_cnt;
  logic tog_tick;
  logic [15:0] ring_cnt;
  logic [15:0] next_ring_cnt;

  always_comb begin
    tog_tick = tog_cnt == 28'(TOGGLE_CYCLES - 1); // [RL19]
    next_tog_cnt = tog_tick ? 28'h0 : tog_cnt + 28'h1;
    next_ring_cnt = ring_cnt;
    if (ring_toggle) begin
      next_ring_cnt = `BVS_RING_IDLE;
    end else if (ring_cnt != 16'h0) begin
      next_ring_cnt = ring_cnt - 16'h1;
    end
    ring_active = ring_cnt != 16'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_cnt <= 28'h0;
      ring_cnt <= 16'h0;
    end else begin
      tog_cnt <= next_tog_cnt;
      ring_cnt <= next_ring_cnt;
    end
  end

  // ---------------------------------------------------------------
  // ring command registers and status pins
  // ---------------------------------------------------------------
  logic [1:0] ring_command_reg0;
  logic ring_command_reg1;
  logic [2:0] pin_target;
  logic [1:0] next_reg0;
  logic next_reg1;

  always_comb begin
    pin_target = pins_of(next_state); // [RL9]
    if (state == BVS_CMD) begin
      pin_target = {ring_command_reg0[1], ring_command_reg0[0] ^ tog_tick,
                    ring_command_reg1 ^ tog_tick}; // [RL7]
    end
    next_reg0 = ring_command_reg0;
    next_reg1 = ring_command_reg1;
    if (ring_active) begin
      next_reg0 = pin_target[2:1]; // [RL13]
      next_reg1 = pin_target[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_command_reg0 <= 2'h3;
      ring_command_reg1 <= 1'b0;
      frame_acquire_out <= 1'b1;
      insert_request_out <= 1'b1;
      loopback_out <= 1'b0;
      frame_acquire_oe <= 1'b0;
      insert_request_oe <= 1'b0;
      loopback_oe <= 1'b0;
    end else begin
      ring_command_reg0 <= next_reg0;
      ring_command_reg1 <= next_reg1;
      frame_acquire_out <= next_reg0[1];
      insert_request_out <= next_reg0[0];
      loopback_out <= next_reg1;
      frame_acquire_oe <= next_test_filt; // [RL12]
      insert_request_oe <= next_test_filt;
      loopback_oe <= next_test_filt;
    end
  end

  // ---------------------------------------------------------------
  // open-time expansion memory test
  // ---------------------------------------------------------------
  bvs_mstate_t next_mstate;
  logic [15:0] next_maddr;
  logic next_mwe;
  logic next_mre;
  logic next_mem_err;
  logic next_mem_ok;

  always_comb begin
    next_mstate = mstate;
    next_maddr = mem_addr_out;
    next_mwe = 1'b0;
    next_mre = 1'b0;
    next_mem_err = mem_err;
    next_mem_ok = mem_ok;
    unique case (mstate)
      BVS_M_IDLE: begin
        if (wr_mem && hwdata[0]) begin
          next_mstate = BVS_M_WR; // [RL15]
          next_maddr = `BVS_MEM_LO;
          next_mwe = 1'b1;
          next_mem_err = 1'b0;
          next_mem_ok = 1'b0;
        end
      end
      BVS_M_WR: begin
        next_mstate = BVS_M_RD;
        next_mre = 1'b1;
      end
      BVS_M_RD: next_mstate = BVS_M_CMP;
      BVS_M_CMP: begin
        if (mem_rdata != `BVS_MEM_PAT) begin
          next_mstate = BVS_M_IDLE;
          next_mem_err = 1'b1; // [RL16]
        end else if (mem_addr_out == `BVS_MEM_HI) begin
          next_mstate = BVS_M_IDLE;
          next_mem_ok = 1'b1;
        end else begin
          next_mstate = BVS_M_WR;
          next_maddr = mem_addr_out + `BVS_MEM_STEP;
          next_mwe = 1'b1;
        end
      end
      default: next_mstate = BVS_M_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mstate <= BVS_M_IDLE;
      mem_addr_out <= 16'h0;
      mem_wdata_out <= `BVS_MEM_PAT;
      mem_we_out <= 1'b0;
      mem_re_out <= 1'b0;
      mem_err <= 1'b0;
      mem_ok <= 1'b0;
      instruction_data_select <= 1'b0;
    end else begin
      mstate <= next_mstate;
      mem_addr_out <= next_maddr;
      mem_wdata_out <= `BVS_MEM_PAT;
      mem_we_out <= next_mwe;
      mem_re_out <= next_mre;
      mem_err <= next_mem_err;
      mem_ok <= next_mem_ok;
      instruction_data_select <= 1'b0; // [RL16]
    end
  end

endmodule : bvs_top
`default_nettype wire

// File: bench/bvs_mem_model.sv
// expansion memory model answering the open-time memory test
`default_nettype none
module bvs_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic mem_we_out,
  input wire logic mem_re_out,
  output logic [15:0] mem_rdata
);
  logic [15:0] last_addr;
  logic [15:0] last_data;
  // ------------------------------------------------
  // store on write, answer the cycle after a read
  // ------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_addr <= 16'h0000;
      last_data <= 16'h0000;
      mem_rdata <= 16'h0000;
    end else begin
      if (mem_we_out) begin
        last_addr <= mem_addr_out;
        last_data <= mem_wdata_out;
      end
      if (mem_re_out && mem_addr_out == last_addr) begin
        mem_rdata <= last_data;
      end else begin
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule : bvs_mem_model
`default_nettype wire

// File: bench/bvs_checker.sv
// concurrent checks on the sequencer ports
`default_nettype none
`include "bvs_defs.svh"
module bvs_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic handler_test_n,
  input wire logic frame_acquire_out,
  input wire logic frame_acquire_oe,
  input wire logic insert_request_out,
  input wire logic insert_request_oe,
  input wire logic loopback_out,
  input wire logic loopback_oe,
  input wire logic [15:0] dl_addr_out,
  input wire logic dl_we_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic mem_we_out,
  input wire logic mem_re_out,
  input wire logic instruction_data_select
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------
  // sequences
  // ------------------------------------------------
  sequence s_word_write;
    mem_we_out;
  endsequence
  sequence s_word_read;
    mem_re_out && $stable(mem_addr_out) ##1 !mem_we_out && !mem_re_out;
  endsequence
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_read_idle: assert property (!(hsel && hready && htrans[1] && !hwrite
    && hsize == `BVS_SIZE_WORD) |=> hrdata == 32'h0)
    else $error("read data not zero without read");
  a_data_part: assert property (!instruction_data_select)
    else $error("instruction partition selected");
  a_mem_range: assert property (mem_we_out |-> mem_addr_out >= `BVS_MEM_LO
    && mem_addr_out <= `BVS_MEM_HI && !mem_addr_out[0] && mem_wdata_out == `BVS_MEM_PAT)
    else $error("memory test write out of range");
  a_mem_order: assert property (s_word_write |=> s_word_read)
    else $error("memory test word order wrong");
  a_dl_range: assert property (dl_we_out |-> dl_addr_out >= `BVS_DBG_LO
    && dl_addr_out <= `BVS_DBG_HI)
    else $error("download write out of range");
  a_pins_float: assert property (!handler_test_n [*6] |-> !frame_acquire_oe
    && !insert_request_oe && !loopback_oe)
    else $error("status pins driven in test mode");
  a_toggle_pair: assert property (!frame_acquire_out && !$past(frame_acquire_out)
    && $changed(insert_request_out) |-> $changed(loopback_out))
    else $error("insert and loopback did not toggle together");
endmodule : bvs_checker
bind bvs_top bvs_checker bvs_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .handler_test_n(handler_test_n),
  .frame_acquire_out(frame_acquire_out), .frame_acquire_oe(frame_acquire_oe),
  .insert_request_out(insert_request_out), .insert_request_oe(insert_request_oe),
  .loopback_out(loopback_out), .loopback_oe(loopback_oe), .dl_addr_out(dl_addr_out),
  .dl_we_out(dl_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
  .mem_we_out(mem_we_out), .mem_re_out(mem_re_out),
  .instruction_data_select(instruction_data_select));
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench of the bus verify status sequencer
`default_nettype none
`include "bvs_defs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bvs_pkg::*;
  localparam int TOG = 64;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ring_en = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h0;
  logic [3:0] ev = 4'h0;
  logic strap = 1'b1, ring_clk = 1'b0, test_n = 1'b1;
  logic hreadyout, hresp, fa, fa_oe, ins, ins_oe, lb, lb_oe, cstb, dl_we, m_we, m_re, ids;
  logic [7:0] cmd;
  logic [15:0] dl_a, dl_d, m_a, m_wd, m_rd;
  logic [15:0] codes [4] = '{`BVS_CODE_P2, `BVS_CODE_P3, `BVS_CODE_P4, `BVS_CODE_P5};
  logic [2:0] pinv [4] = '{`BVS_PIN_P2, `BVS_PIN_P3, `BVS_PIN_P4, `BVS_PIN_P5};
  int n_fail = 0, check_count = 0, n;
  wire logic [2:0] pins = {fa, ins, lb};
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) ring_clk <= ring_en ? ~ring_clk : ring_clk;
  bvs_top #(.TOGGLE_CYCLES(TOG)) bvs_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .phase_pass(ev[0]), .phase_fail(ev[1]), .pattern_fail_55(ev[2]),
    .pattern_fail_2a(ev[3]), .resident_strap(strap), .ring_clock_in(ring_clk),
    .handler_test_n(test_n), .frame_acquire_out(fa), .frame_acquire_oe(fa_oe),
    .insert_request_out(ins), .insert_request_oe(ins_oe), .loopback_out(lb),
    .loopback_oe(lb_oe), .command_out(cmd), .command_strobe(cstb), .dl_addr_out(dl_a),
    .dl_data_out(dl_d), .dl_we_out(dl_we), .mem_addr_out(m_a), .mem_wdata_out(m_wd),
    .mem_we_out(m_we), .mem_re_out(m_re), .mem_rdata(m_rd), .instruction_data_select(ids));
  bvs_mem_model bvs_mem_model_i (.hclk(hclk), .hresetn(hresetn), .mem_addr_out(m_a),
    .mem_wdata_out(m_wd), .mem_we_out(m_we), .mem_re_out(m_re), .mem_rdata(m_rd));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= `BVS_SIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic do_reset(input logic s);
    strap <= s;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : do_reset
  task automatic pulse(input int i);
    @(posedge hclk);
    ev[i] <= 1'b1;
    @(posedge hclk);
    ev[i] <= 1'b0;
  endtask : pulse
  task automatic chk_ph(input logic [15:0] c, input logic [2:0] p);
    ahb(1'b0, `BVS_A_INT, 32'h0, d);
    `CHK("int code", c, d[15:0])
    `CHK("status pins", p, pins)
  endtask : chk_ph
  task automatic to_p5();
    chk_ph(`BVS_CODE_P1, `BVS_PIN_P1);
    for (int i = 0; i < 4; i++) begin
      pulse(0);
      chk_ph(codes[i], pinv[i]);
    end
  endtask : to_p5
  task automatic gap();
    n = 0;
    d[0] = ins;
    do begin @(negedge hclk); n++; end while (ins === d[0] && n < 300);
  endtask : gap
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    for (int r = 0; r < 2; r++) begin
      do_reset(1'b1);
      to_p5();
      pulse(2 + r);
      pulse(0);
      chk_ph(r ? `BVS_CODE_F2A : `BVS_CODE_F55, `BVS_PIN_P5);
      ahb(1'b0, `BVS_A_STAT, 32'h0, d);
      `CHK("failed", 1'b1, d[9])
    end
    $display("test pattern failures done");
    do_reset(1'b1);
    to_p5();
    pulse(0);
    ahb(1'b0, `BVS_A_INT, 32'h0, d);
    `CHK("int code", `BVS_CODE_CMD, d[15:0])
    `CHK("pin pair", {1'b0, ~lb}, {fa, ins})
    ahb(1'b0, `BVS_A_STAT, 32'h0, d);
    `CHK("state", BVS_CMD, d[6:0])
    gap();
    d[1] = lb;
    gap();
    `CHK("toggle gap", TOG, n)
    `CHK("loopback", ~d[1], lb)
    @(posedge hclk);
    ahb(1'b1, `BVS_A_INT, 32'h00005a00, d);
    @(negedge hclk);
    `CHK("command strobe", 1'b1, cstb)
    `CHK("command", 8'h5a, cmd)
    @(posedge hclk);
    $display("test command state done");
    do_reset(1'b1);
    pulse(0);
    ring_en <= 1'b0;
    repeat (90) @(posedge hclk);
    pulse(0);
    chk_ph(`BVS_CODE_P3, `BVS_PIN_P2);
    ring_en <= 1'b1;
    pulse(1);
    pulse(0);
    chk_ph(`BVS_CODE_P3, `BVS_PIN_P3);
    test_n <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK("oe", 3'h0, {fa_oe, ins_oe, lb_oe})
    test_n <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK("oe", 3'h7, {fa_oe, ins_oe, lb_oe})
    $display("test hang and pin gating done");
    for (int r = 0; r < 2; r++) begin
      do_reset(1'b0);
      ahb(1'b0, `BVS_A_STAT, 32'h0, d);
      `CHK("idle", {1'b0, BVS_IDLE}, {d[11], d[6:0]})
      ahb(1'b1, `BVS_A_INT, {16'h0, `BVS_CMD_DLOAD, 8'h00}, d);
      ahb(1'b1, `BVS_A_DL, 32'h3ffe1234, d);
      ahb(1'b1, `BVS_A_INT, {16'h0, `BVS_CMD_EXEC, 8'h00}, d);
      ahb(1'b0, `BVS_A_STAT, 32'h0, d);
      `CHK("no start", 2'b01, d[11:10])
      ahb(1'b1, `BVS_A_DL, 32'h4000beef, d);
      ahb(1'b0, `BVS_A_DL, 32'h0, d);
      `CHK("download", 32'h4000beef, d)
      ahb(1'b1, `BVS_A_INT, {16'h0, `BVS_CMD_EXEC, 8'h00}, d);
      ahb(1'b0, `BVS_A_STAT, 32'h0, d);
      `CHK("exec", BVS_P1, d[6:0])
    end
    $display("test download done");
    ahb(1'b1, `BVS_A_MEM, 32'h1, d);
    n = 0;
    do begin ahb(1'b0, `BVS_A_MEM, 32'h0, d); n++; end while (d[0] !== 1'b0 && n < 40000);
    `CHK("memory test", 2'b10, d[2:1])
    `CHK("data partition", 1'b0, ids)
    $display("test memory done");
    conclude();
  end
  initial begin
    repeat (90000) @(posedge hclk);
    n_fail++;
    conclude();
  end
endmodule : testbench
`undef CHK
`default_nettype wire
